// *** verilog/ts_params.svh ***
// Functional notes
// - Receive-capture bit latches count at rx start.
// - Rx start equals rx frame start interrupt.
// - No capture bits: bytes show live count.
// - Transmit-clear bit zeroes count at tx start.
// - Receive-clear bit zeroes count at rx start.
// - Enable bit runs counter; zero holds it cleared.
// - Four count bytes, byte 0 least significant.
// - One count per 32 MHz period.
// - Reset loads defaults, enters transceiver-off state.
// - Counter stops in reset and sleep states.
// - Count wraps from maximum to zero.
// - Transmit-capture bit latches count at PA rise.
// - Captured value held until next capture.
`ifndef TS_PARAMS_SVH
`define TS_PARAMS_SVH

`define TS_CFG_EN 0
`define TS_CFG_CLR_RX 1
`define TS_CFG_CLR_TX 2
`define TS_CFG_CAP_RX 3
`define TS_CFG_CAP_TX 4
`define TS_CFG_WIDTH 5
`define TS_CFG_RESET 5'h00
`define TS_COUNT_RESET 32'h0000_0000

`define TS_ADDR_WIDTH 14
`define TS_ADDR_CONFIG 14'h0000
`define TS_ADDR_BYTE0 14'h0001
`define TS_ADDR_BYTE1 14'h0002
`define TS_ADDR_BYTE2 14'h0003
`define TS_ADDR_BYTE3 14'h0004
`define TS_UNMAPPED_DATA 8'h00

`define TS_SPI_WRITE_BIT 15
`define TS_SPI_HDR_LAST 4'hF
`define TS_SPI_BYTE_LAST 4'h7

`define TS_SYS_PERIOD_PS 16'hFA0
`define TS_TICK_PERIOD_PS 16'h7A12

`endif

// *** verilog/ts_pkg.sv ***
package ts_pkg;
`include "ts_params.svh"

    typedef enum logic [1:0] {SPI_IDLE, SPI_HEADER, SPI_DATA} spi_phase_e;

    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_s;

    typedef struct packed {
        logic [15:0] acc;
        logic tick;
    } tick_state_s;

    typedef struct packed {
        spi_phase_e phase;
        logic sclk_prev;
        logic [3:0] bit_cnt;
        logic [15:0] shift_in;
        logic [`TS_ADDR_WIDTH-1:0] addr;
        logic is_write;
        logic rd_cont;
        logic rd_req;
        logic wr_req;
        logic [`TS_ADDR_WIDTH-1:0] req_addr;
        logic [7:0] wr_data;
        logic [7:0] shift_out;
        logic miso;
        logic miso_oe;
        logic [`TS_CFG_WIDTH-1:0] cfg;
        logic [31:0] count;
        logic [31:0] captured;
        logic [31:0] snap;
        logic pa_prev;
        logic off_state;
    } top_state_s;

endpackage : ts_pkg

// *** verilog/ts_sync2.sv ***
`timescale 1ns/1ns
module ts_sync2 import ts_pkg::*; #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    sync_state_s s_q;
    sync_state_s s_d;

    // The first stage feeds only the second stage.
    always_comb
    begin
        s_d = s_q;
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= {RESET_LEVEL, RESET_LEVEL};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.sync;
endmodule : ts_sync2

// *** verilog/ts_tick_divider.sv ***
`timescale 1ns/1ns
module ts_tick_divider import ts_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    tick_state_s s_q;
    tick_state_s s_d;
    logic [16:0] sum;

    // Phase accumulator in picoseconds; ticks average exactly 32 MHz with 4 ns jitter.
    assign sum = {1'b0, s_q.acc} + {1'b0, `TS_SYS_PERIOD_PS};

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (sum >= {1'b0, `TS_TICK_PERIOD_PS})
        begin
            s_d.acc = 16'(sum - {1'b0, `TS_TICK_PERIOD_PS});
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.acc = sum[15:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : ts_tick_divider

// *** verilog/frame_timestamp_counter.sv ***
`timescale 1ns/1ns
module frame_timestamp_counter import ts_pkg::*; (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic SPI_SCLK,
    input wire logic SPI_MOSI,
    input wire logic SPI_CS_N,
    output logic SPI_MISO,
    output logic SPI_MISO_OE,
    input wire logic RX_FRAME_START_IRQ,
    input wire logic PA_ENABLE,
    input wire logic TRX_LOW_POWER,
    input wire logic TRX_ACTIVE,
    output logic TRANSCEIVER_OFF_STATE
);
    localparam top_state_s RESET_STATE = '{
        phase: SPI_IDLE,
        sclk_prev: 1'b0,
        bit_cnt: 4'h0,
        shift_in: 16'h0000,
        addr: 14'h0000,
        is_write: 1'b0,
        rd_cont: 1'b0,
        rd_req: 1'b0,
        wr_req: 1'b0,
        req_addr: 14'h0000,
        wr_data: 8'h00,
        shift_out: 8'h00,
        miso: 1'b0,
        miso_oe: 1'b0,
        cfg: `TS_CFG_RESET,
        count: `TS_COUNT_RESET,
        captured: `TS_COUNT_RESET,
        snap: `TS_COUNT_RESET,
        pa_prev: 1'b0,
        off_state: 1'b1
    };

    top_state_s s_q;
    top_state_s s_d;
    logic sclk_s;
    logic mosi_s;
    logic cs_n_s;
    logic tick;
    logic sclk_rise;
    logic sclk_fall;
    logic rx_ev;
    logic tx_ev;
    logic capture_mode;
    logic do_capture;
    logic do_clear;
    logic count_step;
    logic [31:0] shown;
    logic [15:0] hdr_word;
    logic [7:0] data_byte;
    logic [7:0] rd_byte;

    function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] idx);
        byte_of = word[8*idx +: 8];
    endfunction : byte_of

    function automatic logic event_hit(input logic sel_rx, input logic sel_tx,
        input logic rx, input logic tx);
        event_hit = (sel_rx & rx) | (sel_tx & tx);
    endfunction : event_hit

    // Bytes after byte 0 in one block come from the snapshot, so a carry between
    // reads cannot tear the value.
    function automatic logic [31:0] block_word(input logic cont, input logic [31:0] held,
        input logic [31:0] live);
        block_word = cont ? held : live;
    endfunction : block_word

    // The rollover is written out so that the wrap does not hide in a truncation.
    function automatic logic [31:0] next_count(input logic [31:0] c);
        if (c == 32'hFFFF_FFFF)
        begin
            next_count = `TS_COUNT_RESET;
        end
        else
        begin
            next_count = c + 32'h0000_0001;
        end
    endfunction : next_count

    // Serial pins come from another clock domain and pass two stages before use.
    ts_sync2 #(.RESET_LEVEL(1'b0)) u_sync_sclk (
        .clk(CLK_SYS),
        .rst(RESET),
        .din(SPI_SCLK),
        .dout(sclk_s)
    );

    ts_sync2 #(.RESET_LEVEL(1'b0)) u_sync_mosi (
        .clk(CLK_SYS),
        .rst(RESET),
        .din(SPI_MOSI),
        .dout(mosi_s)
    );

    ts_sync2 #(.RESET_LEVEL(1'b1)) u_sync_cs (
        .clk(CLK_SYS),
        .rst(RESET),
        .din(SPI_CS_N),
        .dout(cs_n_s)
    );

    ts_tick_divider u_tick (
        .clk(CLK_SYS),
        .rst(RESET),
        .tick(tick)
    );

    assign sclk_rise = sclk_s & ~s_q.sclk_prev;
    assign sclk_fall = ~sclk_s & s_q.sclk_prev;
    assign hdr_word = {s_q.shift_in[14:0], mosi_s};
    assign data_byte = hdr_word[7:0];

    // Frame start events come from logic on this clock, so no synchroniser is needed.
    assign rx_ev = RX_FRAME_START_IRQ;
    assign tx_ev = PA_ENABLE & ~s_q.pa_prev;

    assign capture_mode = s_q.cfg[`TS_CFG_CAP_RX] | s_q.cfg[`TS_CFG_CAP_TX];
    assign do_capture = event_hit(s_q.cfg[`TS_CFG_CAP_RX], s_q.cfg[`TS_CFG_CAP_TX],
        rx_ev, tx_ev);
    assign do_clear = event_hit(s_q.cfg[`TS_CFG_CLR_RX], s_q.cfg[`TS_CFG_CLR_TX],
        rx_ev, tx_ev);
    // Low power pauses the count rather than clearing it, so the timeline resumes on wake-up.
    assign count_step = tick & ~TRX_LOW_POWER;

    // Capture mode shows the held value, otherwise the live count.
    assign shown = capture_mode ? s_q.captured : s_q.count;

    // In a block that starts at byte 0, bytes 1 to 3 come from the snapshot taken when byte 0 was read.
    always_comb
    begin
        rd_byte = `TS_UNMAPPED_DATA;
        unique case (s_q.req_addr)
            `TS_ADDR_CONFIG:
            begin
                rd_byte = {3'b000, s_q.cfg};
            end
            `TS_ADDR_BYTE0:
            begin
                rd_byte = byte_of(shown, 2'd0);
            end
            `TS_ADDR_BYTE1:
            begin
                rd_byte = byte_of(block_word(s_q.rd_cont, s_q.snap, shown), 2'd1);
            end
            `TS_ADDR_BYTE2:
            begin
                rd_byte = byte_of(block_word(s_q.rd_cont, s_q.snap, shown), 2'd2);
            end
            `TS_ADDR_BYTE3:
            begin
                rd_byte = byte_of(block_word(s_q.rd_cont, s_q.snap, shown), 2'd3);
            end
            default:
            begin
                rd_byte = `TS_UNMAPPED_DATA;
            end
        endcase
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rd_req = 1'b0;
        s_d.wr_req = 1'b0;
        s_d.sclk_prev = sclk_s;
        s_d.pa_prev = PA_ENABLE;
        s_d.off_state = ~TRX_ACTIVE;

        // Capture reads the count before any clear of the same event lands.
        if (do_capture)
        begin
            s_d.captured = s_q.count;
        end

        if (!s_q.cfg[`TS_CFG_EN])
        begin
            s_d.count = `TS_COUNT_RESET;
        end
        else if (do_clear)
        begin
            s_d.count = `TS_COUNT_RESET;
        end
        else if (count_step)
        begin
            s_d.count = next_count(s_q.count);
        end

        if (s_q.rd_req)
        begin
            s_d.shift_out = rd_byte;
            if (s_q.req_addr == `TS_ADDR_BYTE0)
            begin
                s_d.snap = shown;
            end
        end

        // Only the configuration register accepts writes; count bytes are read-only.
        if (s_q.wr_req && s_q.req_addr == `TS_ADDR_CONFIG)
        begin
            s_d.cfg = s_q.wr_data[`TS_CFG_WIDTH-1:0];
        end

        // Dropping a partial byte on release keeps a cut frame out of the next one.
        if (cs_n_s)
        begin
            s_d.phase = SPI_IDLE;
            s_d.miso_oe = 1'b0;
            s_d.miso = 1'b0;
            s_d.shift_out = 8'h00;
        end
        else
        begin
            s_d.miso_oe = 1'b1;
            unique case (s_q.phase)
                SPI_IDLE:
                begin
                    s_d.phase = SPI_HEADER;
                    s_d.bit_cnt = 4'h0;
                    s_d.rd_cont = 1'b0;
                end
                SPI_HEADER:
                begin
                    if (sclk_rise)
                    begin
                        s_d.shift_in = hdr_word;
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        if (s_q.bit_cnt == `TS_SPI_HDR_LAST)
                        begin
                            s_d.phase = SPI_DATA;
                            s_d.bit_cnt = 4'h0;
                            s_d.is_write = hdr_word[`TS_SPI_WRITE_BIT];
                            s_d.addr = hdr_word[`TS_ADDR_WIDTH-1:0];
                            s_d.req_addr = hdr_word[`TS_ADDR_WIDTH-1:0];
                            s_d.rd_req = ~hdr_word[`TS_SPI_WRITE_BIT];
                        end
                    end
                end
                SPI_DATA:
                begin
                    if (sclk_rise)
                    begin
                        s_d.shift_in = hdr_word;
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        if (s_q.bit_cnt == `TS_SPI_BYTE_LAST)
                        begin
                            s_d.bit_cnt = 4'h0;
                            s_d.addr = s_q.addr + 14'h0001;
                            if (s_q.is_write)
                            begin
                                s_d.wr_req = 1'b1;
                                s_d.wr_data = data_byte;
                                s_d.req_addr = s_q.addr;
                            end
                            else
                            begin
                                // The next byte is fetched now so it is ready before the next fall.
                                s_d.rd_req = 1'b1;
                                s_d.rd_cont = 1'b1;
                                s_d.req_addr = s_q.addr + 14'h0001;
                            end
                        end
                    end
                end
                // An unused phase code falls back to idle rather than locking the port.
                default:
                begin
                    s_d.phase = SPI_IDLE;
                end
            endcase
            // Data leaves on the falling edge so the host can sample it on the next rise.
            if (sclk_fall)
            begin
                s_d.miso = s_q.shift_out[7];
                s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
            end
        end
    end

    // All register defaults, including configuration and count, load here.
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            s_q <= RESET_STATE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign SPI_MISO = s_q.miso;
    assign SPI_MISO_OE = s_q.miso_oe;
    assign TRANSCEIVER_OFF_STATE = s_q.off_state;
endmodule : frame_timestamp_counter

// *** testbench/ts_checker_assertions.sv ***
`timescale 1ns/1ns
module ts_checker (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MISO,
    input wire logic SPI_MISO_OE,
    input wire logic TRX_ACTIVE,
    input wire logic TRANSCEIVER_OFF_STATE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);
    // Windows leave room for the two-stage chip-select synchroniser.
    sequence s_open;
        $fell(SPI_CS_N);
    endsequence
    sequence s_close;
        $rose(SPI_CS_N);
    endsequence
    property p_rel_state;
        $fell(RESET) |-> TRANSCEIVER_OFF_STATE && !SPI_MISO_OE && !SPI_MISO;
    endproperty
    property p_off_mirror;
        !$past(RESET) |-> TRANSCEIVER_OFF_STATE == !$past(TRX_ACTIVE);
    endproperty
    property p_oe_on;
        s_open |-> ##[2:4] SPI_MISO_OE;
    endproperty
    property p_oe_off;
        s_close |-> ##[2:4] !SPI_MISO_OE;
    endproperty
    property p_oe_hold;
        !SPI_CS_N [*5] |-> SPI_MISO_OE;
    endproperty
    property p_idle_low;
        SPI_CS_N [*6] |-> !SPI_MISO && !SPI_MISO_OE;
    endproperty
    property p_miso_stable;
        SPI_SCLK && $past(SPI_SCLK) |-> $stable(SPI_MISO);
    endproperty
    property p_miso_close;
        s_close |-> ##[2:4] !SPI_MISO;
    endproperty
    a_rel_state: assert property (p_rel_state)
        else $error("outputs wrong after reset");
    a_off_mirror: assert property (p_off_mirror)
        else $error("off state does not follow activity");
    a_oe_on: assert property (p_oe_on)
        else $error("output enable late");
    a_oe_off: assert property (p_oe_off)
        else $error("output enable stuck");
    a_oe_hold: assert property (p_oe_hold)
        else $error("output enable dropped in frame");
    a_idle_low: assert property (p_idle_low)
        else $error("data line active when idle");
    a_miso_stable: assert property (p_miso_stable)
        else $error("data changed while clock high");
    a_miso_close: assert property (p_miso_close)
        else $error("data line not low after frame");
endmodule : ts_checker
bind frame_timestamp_counter ts_checker i_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .SPI_MISO(SPI_MISO),
    .SPI_MISO_OE(SPI_MISO_OE), .TRX_ACTIVE(TRX_ACTIVE),
    .TRANSCEIVER_OFF_STATE(TRANSCEIVER_OFF_STATE));

// *** testbench/ts_spi_host.sv ***
`timescale 1ns/1ns
module ts_spi_host (
    input wire logic clk,
    input wire logic miso,
    output logic sclk,
    output logic mosi,
    output logic cs_n
);
    initial
    begin
        sclk = 1'b0;
        mosi = 1'b1;
        cs_n = 1'b1;
    end
    // Six cycles per clock phase keeps the serial clock under its limit.
    task automatic xfer(input logic [15:0] hdr, input logic [7:0] wd, input int n,
        output logic [31:0] rd);
        logic [47:0] sr;
        sr = {hdr, wd, 24'h0};
        rd = 32'h0;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 16 + 8 * n; i++)
        begin
            @(posedge clk);
            sclk <= 1'b0;
            mosi <= sr[47];
            repeat (5) @(posedge clk);
            @(posedge clk);
            sclk <= 1'b1;
            if (i >= 16)
                rd[8 * ((i - 16) / 8) + 7 - (i - 16) % 8] = miso;
            sr = sr << 1;
            repeat (5) @(posedge clk);
        end
        @(posedge clk);
        sclk <= 1'b0;
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        // A released line must not keep showing its last bit.
        mosi <= ~mosi;
        repeat (4) @(posedge clk);
    endtask : xfer
endmodule : ts_spi_host

// *** testbench/frame_timestamp_counter_test.sv ***
`timescale 1ns/1ns
`include "ts_params.svh"
module frame_timestamp_counter_test import ts_pkg::*; ;
    logic clk, rst, rx, pa, lowp, act, sclk, mosi, cs_n, miso, miso_oe, off;
    int n_fail, checked, cyc, t0, ta;
    logic [31:0] a, b, junk;
    logic [31:0] rows[6] = '{32'h0000FF1F, 32'h00001E1E, 32'h00000606,
        32'h00015500, 32'h0005AA00, 32'h00000000};
    frame_timestamp_counter i_dut (.CLK_SYS(clk), .RESET(rst), .SPI_SCLK(sclk),
        .SPI_MOSI(mosi), .SPI_CS_N(cs_n), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
        .RX_FRAME_START_IRQ(rx), .PA_ENABLE(pa), .TRX_LOW_POWER(lowp),
        .TRX_ACTIVE(act), .TRANSCEIVER_OFF_STATE(off));
    ts_spi_host i_host (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi), .cs_n(cs_n));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic near(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp && got !== exp + 32'h1 && got !== exp - 32'h1)
        begin
            n_fail++;
            $display("[ERR] %0t got %h near %h", $time, got, exp);
        end
    endtask : near
    task automatic wr(input logic [13:0] ad, input logic [7:0] d);
        i_host.xfer({2'b10, ad}, d, 1, junk);
    endtask : wr
    task automatic blk(output logic [31:0] v);
        t0 = cyc;
        i_host.xfer({2'b00, `TS_ADDR_BYTE0}, 8'h00, 4, v);
    endtask : blk
    task automatic fire(input logic tx, input int t);
        do
            @(posedge clk);
        while (cyc < t);
        if (tx)
            pa <= 1'b1;
        else
            rx <= 1'b1;
        @(posedge clk);
        pa <= 1'b0;
        rx <= 1'b0;
    endtask : fire
    task automatic results;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial
    begin
        rst = 1'b1;
        rx = 1'b0;
        pa = 1'b0;
        lowp = 1'b0;
        act = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, off}, 32'h1);
        i_host.xfer({2'b00, `TS_ADDR_CONFIG}, 8'h00, 1, a);
        chk(a, 32'h0);
        blk(a);
        chk(a, 32'h0);
        act <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, off}, 32'h0);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(rows[i][29:16], rows[i][15:8]);
            i_host.xfer({2'b00, rows[i][29:16]}, 8'h00, 1, a);
            chk(a, {24'h0, rows[i][7:0]});
            blk(a);
            chk(a, 32'h0);
        end
        $display("register test done");
        wr(`TS_ADDR_CONFIG, 8'h01);
        blk(a);
        ta = t0;
        repeat (2000) @(posedge clk);
        blk(b);
        near(b - a, (t0 - ta) * 32 / 250);
        lowp <= 1'b1;
        blk(a);
        repeat (1000) @(posedge clk);
        blk(b);
        chk(b, a);
        lowp <= 1'b0;
        $display("free running test done");
        for (int k = 0; k < 2; k++)
        begin
            wr(`TS_ADDR_CONFIG, k ? 8'h15 : 8'h0B);
            fire(k[0], 0);
            ta = cyc;
            fire(k[0], ta + 5000);
            blk(a);
            near(a, 32'h280);
            wr(`TS_ADDR_CONFIG, k ? 8'h11 : 8'h09);
            fire(k[0], ta + 10000);
            fire(k[0], ta + 15000);
            blk(a);
            near(a, 32'h500);
            repeat (500) @(posedge clk);
            blk(b);
            chk(b, a);
            i_host.xfer({2'b00, `TS_ADDR_BYTE1}, 8'h00, 1, b);
            chk(b, {24'h0, a[15:8]});
            $display("event test done");
        end
        results();
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule : frame_timestamp_counter_test
